// >>> sim/irq_src_model.sv
// Interrupt controller and timer model driving the trap block's sources
`timescale 1ns/1ps
module irq_src_model (
  input wire logic clock_in,
  output logic top_ext_req_out,
  output logic sup_ext_req_out,
  output logic top_soft_level_out,
  output logic timer_fire_out,
  output logic timer_cmp_write_out,
  output logic sup_soft_set_out
);
  initial begin
    {top_ext_req_out, sup_ext_req_out, top_soft_level_out} = 3'h0;
    {timer_fire_out, timer_cmp_write_out, sup_soft_set_out} = 3'h0;
  end
  // ----------------------------------------------------------------
  // Request levels, held until the controller changes them
  // ----------------------------------------------------------------
  task automatic set_lines(input logic [2:0] lv);
    @(posedge clock_in);
    #1;
    {top_ext_req_out, sup_ext_req_out, top_soft_level_out} = lv;
  endtask : set_lines
  // One-cycle events: timer fire, compare write, supervisor soft set
  task automatic pulse(input logic [2:0] ev);
    @(posedge clock_in);
    #1;
    {timer_fire_out, timer_cmp_write_out, sup_soft_set_out} = ev;
    @(posedge clock_in);
    #1;
    {timer_fire_out, timer_cmp_write_out, sup_soft_set_out} = 3'h0;
  endtask : pulse
endmodule : irq_src_model

// >>> sim/tb_trap_delegation_interrupt_ctrl.sv
// Self-checking bench for the trap delegation and interrupt block
`timescale 1ns/1ps
`include "trap_deleg_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_trap_delegation_interrupt_ctrl;
  logic clock_in, srst_in, csr_valid_in, top_global_irq_on_in;
  logic [1:0] csr_sel_in, csr_op_in, cur_level_in;
  logic [63:0] csr_wdata_in, csr_rdata_out, exc_pc_in, exc_value_in;
  logic trap_return_instr_in, exc_valid_in, sup_global_irq_on_in;
  logic [3:0] exc_code_in, irq_cause_out;
  logic te, se, sl, tf, tc, ss, irq_take_out, trap_to_sup_out;
  logic top_trap_write_out, sup_prior_level_out, sup_prior_irq_on_out;
  logic sup_global_irq_on_out;
  logic [63:0] sup_trap_cause_out, sup_trap_pc_out, sup_trap_value_out;
  int mismatches = 0, tests_run = 0, cycles = 0;
  typedef struct {logic [1:0] s; logic [1:0] o; logic [15:0] w, e;} row_t;
  row_t rows[8] = '{'{2'h3, 2'h1, 16'hffff, 16'h0aaa},
    '{2'h0, 2'h1, 16'hffff, 16'hf7ff}, '{2'h1, 2'h1, 16'hffff, 16'h0222},
    '{2'h2, 2'h1, 16'hffff, 16'h0222}, '{2'h2, 2'h3, 16'h0020, 16'h0202},
    '{2'h2, 2'h1, 16'h0000, 16'h0000}, '{2'h1, 2'h3, 16'h0222, 16'h0000},
    '{2'h0, 2'h1, 16'h0100, 16'h0100}};
  irq_src_model src_u (.clock_in(clock_in), .top_ext_req_out(te),
    .sup_ext_req_out(se), .top_soft_level_out(sl), .timer_fire_out(tf),
    .timer_cmp_write_out(tc), .sup_soft_set_out(ss));
  trap_delegation_interrupt_ctrl dut_u (.clock_in(clock_in),
    .srst_in(srst_in), .csr_valid_in(csr_valid_in), .csr_sel_in(csr_sel_in),
    .csr_op_in(csr_op_in), .csr_wdata_in(csr_wdata_in),
    .csr_rdata_out(csr_rdata_out), .cur_level_in(cur_level_in),
    .top_global_irq_on_in(top_global_irq_on_in),
    .trap_return_instr_in(trap_return_instr_in), .top_ext_req_in(te),
    .sup_ext_req_in(se), .sup_soft_set_in(ss), .timer_fire_in(tf),
    .timer_cmp_write_in(tc), .top_soft_level_in(sl),
    .exc_valid_in(exc_valid_in), .exc_code_in(exc_code_in),
    .exc_pc_in(exc_pc_in), .exc_value_in(exc_value_in),
    .sup_global_irq_on_in(sup_global_irq_on_in), .irq_take_out(irq_take_out),
    .irq_cause_out(irq_cause_out), .trap_to_sup_out(trap_to_sup_out),
    .top_trap_write_out(top_trap_write_out),
    .sup_trap_cause_out(sup_trap_cause_out),
    .sup_trap_pc_out(sup_trap_pc_out),
    .sup_trap_value_out(sup_trap_value_out),
    .sup_prior_level_out(sup_prior_level_out),
    .sup_prior_irq_on_out(sup_prior_irq_on_out),
    .sup_global_irq_on_out(sup_global_irq_on_out));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc
  task automatic csr(input logic [1:0] s, o, input logic [15:0] w);
    {csr_valid_in, csr_sel_in, csr_op_in, csr_wdata_in} = {1'b1, s, o,
      48'h0, w};
    cyc(1);
    {csr_valid_in, csr_op_in} = 3'h0;
  endtask : csr
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    csr_sel_in = s;
    #1;
    `CHK(csr_rdata_out, {48'h0, e})
  endtask : rd
  task automatic irq(input logic t, input logic [3:0] c);
    cyc(1);
    `CHK({irq_take_out, irq_cause_out}, {t, c})
  endtask : irq
  // Exception pulse; checks routing now and supervisor state next edge
  task automatic exc(input logic [1:0] lv, input logic [3:0] c,
                     input logic dlg);
    {cur_level_in, exc_code_in, exc_valid_in} = {lv, c, 1'b1};
    exc_pc_in = exc_pc_in + 64'h4;
    exc_value_in = {60'h0, c};
    #1;
    `CHK({trap_to_sup_out, top_trap_write_out}, {dlg, ~dlg})
    cyc(1);
    exc_valid_in = 1'b0;
    if (dlg) begin
      `CHK(sup_trap_cause_out, {60'h0, c})
      `CHK({sup_trap_pc_out, sup_trap_value_out}, {exc_pc_in, exc_value_in})
      `CHK({sup_prior_level_out, sup_prior_irq_on_out, sup_global_irq_on_out},
        {lv[0], sup_global_irq_on_in, 1'b0})
    end
  endtask : exc
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst_in, csr_valid_in, csr_sel_in, csr_op_in, csr_wdata_in} = 70'h0;
    {trap_return_instr_in, exc_valid_in, exc_code_in} = 6'h0;
    cur_level_in = trap_deleg_pkg::PRIV_MACHINE;
    {top_global_irq_on_in, sup_global_irq_on_in} = 2'h3;
    exc_pc_in = 64'h0000_0000_8000_1234;
    exc_value_in = 64'h0000_0000_0000_abcd;
    srst_in = 1'b1;
    cyc(6);
    srst_in = 1'b0;
    for (int i = 0; i < 4; i++) rd(2'(i), 16'h0000);
    foreach (rows[i]) begin
      csr(rows[i].s, rows[i].o, rows[i].w);
      rd(rows[i].s, rows[i].e);
    end
    // Priority among machine-bound sources, each one removed in turn
    src_u.set_lines(3'h7);
    src_u.pulse(3'h4);
    irq(1'b1, 4'(`BIT_TOP_EXT));
    src_u.set_lines(3'h3);
    irq(1'b1, 4'(`BIT_TOP_SOFT));
    src_u.set_lines(3'h2);
    irq(1'b1, 4'(`BIT_TOP_TIMER));
    src_u.pulse(3'h2);
    irq(1'b1, 4'(`BIT_SUP_EXT));
    src_u.set_lines(3'h0);
    csr(`CSR_SEL_PENDING, 2'h1, 16'h0022);
    irq(1'b1, 4'(`BIT_SUP_SOFT));
    csr(`CSR_SEL_PENDING, 2'h1, 16'h0020);
    irq(1'b1, 4'(`BIT_SUP_TIMER));
    top_global_irq_on_in = 1'b0;
    irq(1'b0, 4'(`BIT_SUP_TIMER));
    cur_level_in = trap_deleg_pkg::PRIV_SUPER;
    trap_return_instr_in = 1'b1;
    irq(1'b1, 4'(`BIT_SUP_TIMER));
    trap_return_instr_in = 1'b0;
    csr(`CSR_SEL_IRQ_DELEG, 2'h1, 16'h0020);
    irq(1'b0, 4'h0);
    cur_level_in = trap_deleg_pkg::PRIV_MACHINE;
    top_global_irq_on_in = 1'b1;
    irq(1'b0, 4'h0);
    // Controller request shows in reads but never enters the stored bit
    csr(`CSR_SEL_PENDING, 2'h1, 16'h0000);
    src_u.set_lines(3'h2);
    cyc(1);
    rd(`CSR_SEL_PENDING, 16'h0200);
    csr(`CSR_SEL_PENDING, 2'h2, 16'h0002);
    src_u.set_lines(3'h0);
    cyc(1);
    rd(`CSR_SEL_PENDING, 16'h0002);
    src_u.pulse(3'h1);
    rd(`CSR_SEL_PENDING, 16'h0002);
    // Exceptions with interrupts disabled so none preempts them
    csr(`CSR_SEL_ENABLE, 2'h1, 16'h0000);
    exc(trap_deleg_pkg::PRIV_USER, 4'h8, 1'b1);
    exc(trap_deleg_pkg::PRIV_MACHINE, 4'h8, 1'b0);
    exc(trap_deleg_pkg::PRIV_USER, 4'hb, 1'b0);
    sup_global_irq_on_in = 1'b0;
    exc(trap_deleg_pkg::PRIV_SUPER, 4'h8, 1'b1);
    cyc(2);
    end_of_test();
  end
endmodule : tb_trap_delegation_interrupt_ctrl

// >>> verilog/trap_deleg_params.svh
// Offsets, field positions, reset values and delegation masks for the trap block
`ifndef TRAP_DELEG_PARAMS_SVH
`define TRAP_DELEG_PARAMS_SVH

// CSR select codes on the csr port
`define CSR_SEL_EXC_DELEG 2'h0
`define CSR_SEL_IRQ_DELEG 2'h1
`define CSR_SEL_PENDING 2'h2
`define CSR_SEL_ENABLE 2'h3

// Standard interrupt bit positions
`define BIT_SUP_SOFT 1
`define BIT_TOP_SOFT 3
`define BIT_SUP_TIMER 5
`define BIT_TOP_TIMER 7
`define BIT_SUP_EXT 9
`define BIT_TOP_EXT 11
`define STD_IRQ_BITS 16

// Exception codes
`define EXC_ECALL_TOP 11
`define EXC_CODE_BITS 16

// Delegatable exceptions: all low codes except 11 (machine ecall)
`define EXC_DELEG_MASK 16'hF7FF
// Supervisor interrupt bits only; machine bits never delegatable
`define IRQ_SUP_MASK 16'h0222
`define IRQ_TOP_MASK 16'h0888

`define RESET_ZERO 16'h0000

`endif

// >>> verilog/trap_deleg_pkg.sv
// Types shared by the trap delegation block
package trap_deleg_pkg;

  typedef enum logic [1:0] {
    PRIV_USER = 2'h0,
    PRIV_SUPER = 2'h1,
    PRIV_MACHINE = 2'h3
  } priv_t;

  typedef enum logic [1:0] {
    CSR_OP_WRITE = 2'h1,
    CSR_OP_SET = 2'h2,
    CSR_OP_CLEAR = 2'h3
  } csr_op_t;

endpackage : trap_deleg_pkg

// >>> verilog/trap_delegation_interrupt_ctrl.sv
// Trap delegation masks, interrupt pending/enable and trap routing
`timescale 1ns/1ps
`include "trap_deleg_params.svh"

// What this block does
// - With supervisor present, delegated exceptions from S or U go to supervisor; delegated interrupts are only masked.
// - Delegated trap loads supervisor cause, pc, value, prior level and enable.
// - Delegated trap leaves all machine trap state untouched.
// - No delegation bit is fixed at one; unsupported bits read zero.
// - Traps at machine level stay at machine level regardless of delegation.
// - Delegated interrupts are masked at machine level.
// - Exception delegation bit index equals the exception cause code.
// - Interrupt delegation bits share pending bit layout; supervisor timer bit 5.
// - Exception delegation bit 11 always reads zero.
// - Interrupt cause i maps to bit i; bits 16 up are platform use.
// - Machine trap needs level condition, pending and enabled, not delegated.
// - Trap condition re-evaluated each cycle, including after writes and returns.
// - Machine-bound interrupts win over lower-level interrupts.
// - Writable pending bits clear by writing zero; others clear elsewhere.
// - Enable bits of possible interrupts writable; others read zero.
// - Standard bit positions 11,9,7,5,3,1; other low bits read zero.
// - Machine external pending follows controller request only.
// - Machine timer pending clears only when timer compare is written.
// - Machine software pending follows memory-mapped control; may be zero.
// - Without supervisor, supervisor pending and enable bits read zero.
// - Supervisor external pending reads as software bit OR controller request.
// - Set/clear on pending uses the stored supervisor external bit only.
// - Machine priority: ext, soft, timer, sup ext, sup soft, sup timer.
// - Supervisor timer and software pending are software writable.
module trap_delegation_interrupt_ctrl #(
  parameter int XLEN = 64,
  parameter bit HAS_SUPER = 1'b1,
  parameter bit HAS_TOP_SOFT = 1'b1
) (
  input wire logic clock_in,
  input wire logic srst_in,
  // CSR access port
  input wire logic csr_valid_in,
  input wire logic [1:0] csr_sel_in,
  input wire logic [1:0] csr_op_in,
  input wire logic [XLEN-1:0] csr_wdata_in,
  output logic [XLEN-1:0] csr_rdata_out,
  // Hart state
  input wire logic [1:0] cur_level_in,
  input wire logic top_global_irq_on_in,
  input wire logic trap_return_instr_in,
  // Interrupt sources
  input wire logic top_ext_req_in,
  input wire logic sup_ext_req_in,
  input wire logic sup_soft_set_in,
  input wire logic timer_fire_in,
  input wire logic timer_cmp_write_in,
  input wire logic top_soft_level_in,
  // Synchronous exception raised by the core
  input wire logic exc_valid_in,
  input wire logic [3:0] exc_code_in,
  input wire logic [XLEN-1:0] exc_pc_in,
  input wire logic [XLEN-1:0] exc_value_in,
  input wire logic sup_global_irq_on_in,
  // Trap decisions
  output logic irq_take_out,
  output logic [3:0] irq_cause_out,
  output logic trap_to_sup_out,
  output logic top_trap_write_out,
  // Supervisor trap state
  output logic [XLEN-1:0] sup_trap_cause_out,
  output logic [XLEN-1:0] sup_trap_pc_out,
  output logic [XLEN-1:0] sup_trap_value_out,
  output logic sup_prior_level_out,
  output logic sup_prior_irq_on_out,
  output logic sup_global_irq_on_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam logic [15:0] SUP_MASK = HAS_SUPER ? `IRQ_SUP_MASK : 16'h0000;
  localparam logic [15:0] EXC_MASK = HAS_SUPER ? `EXC_DELEG_MASK : 16'h0000;

  logic [15:0] exc_deleg_q;
  logic [15:0] irq_deleg_q;
  logic [15:0] enable_q;
  logic sup_ext_sw_q;
  logic sup_timer_pending_q;
  logic sup_soft_pending_q;
  logic top_ext_pending_q;
  logic top_timer_pending_q;
  logic top_soft_pending_q;
  logic [15:0] pending_view;
  logic [15:0] pending_store;
  logic [15:0] read_low;
  logic [15:0] wr_low;
  logic [15:0] enable_mask;
  logic is_top;
  logic [15:0] irq_ready;
  logic exc_to_sup;

  assign enable_mask = `IRQ_TOP_MASK & {4'h0, 1'b1, 3'h0,
    1'b1, 3'h0, HAS_TOP_SOFT, 3'h0} | SUP_MASK;
  assign is_top = cur_level_in == trap_deleg_pkg::PRIV_MACHINE;

  // Read view: supervisor external is OR of software bit and request
  always_comb begin
    pending_view = 16'h0000;
    pending_view[`BIT_TOP_EXT] = top_ext_pending_q;
    pending_view[`BIT_TOP_TIMER] = top_timer_pending_q;
    pending_view[`BIT_TOP_SOFT] = HAS_TOP_SOFT & top_soft_pending_q;
    pending_view[`BIT_SUP_EXT] = HAS_SUPER &
      (sup_ext_sw_q | sup_ext_req_in);
    pending_view[`BIT_SUP_TIMER] = HAS_SUPER & sup_timer_pending_q;
    pending_view[`BIT_SUP_SOFT] = HAS_SUPER & sup_soft_pending_q;
  end

  // Stored bits only; request never feeds read-modify-write
  always_comb begin
    pending_store = pending_view;
    pending_store[`BIT_SUP_EXT] = HAS_SUPER & sup_ext_sw_q;
  end

  always_comb begin
    unique case (csr_sel_in)
      `CSR_SEL_EXC_DELEG: read_low = exc_deleg_q & EXC_MASK;
      `CSR_SEL_IRQ_DELEG: read_low = irq_deleg_q & SUP_MASK;
      `CSR_SEL_PENDING: read_low = pending_view;
      `CSR_SEL_ENABLE: read_low = enable_q & enable_mask;
    endcase
  end

  // Bits 16 and up are unimplemented platform sources and read zero
  assign csr_rdata_out = {{(XLEN-16){1'b0}}, read_low};

  function automatic logic [15:0] csr_new(input logic [15:0] old,
                                          input logic [1:0] op,
                                          input logic [15:0] wd);
    logic [15:0] res;
    res = old;
    unique case (op)
      trap_deleg_pkg::CSR_OP_WRITE: res = wd;
      trap_deleg_pkg::CSR_OP_SET: res = old | wd;
      trap_deleg_pkg::CSR_OP_CLEAR: res = old & ~wd;
      default: res = old;
    endcase
    return res;
  endfunction : csr_new

  // ----------------------------------------------------------------
  // Delegation and enable registers
  // ----------------------------------------------------------------
  assign wr_low = csr_wdata_in[15:0];

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      exc_deleg_q <= `RESET_ZERO;
    end else if (csr_valid_in && csr_sel_in == `CSR_SEL_EXC_DELEG) begin
      exc_deleg_q <= csr_new(exc_deleg_q, csr_op_in, wr_low) &
        EXC_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_deleg_q <= `RESET_ZERO;
    end else if (csr_valid_in && csr_sel_in == `CSR_SEL_IRQ_DELEG) begin
      irq_deleg_q <= csr_new(irq_deleg_q, csr_op_in, wr_low) &
        SUP_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      enable_q <= `RESET_ZERO;
    end else if (csr_valid_in && csr_sel_in == `CSR_SEL_ENABLE) begin
      enable_q <= csr_new(enable_q, csr_op_in, wr_low) & enable_mask;
    end
  end

  // ----------------------------------------------------------------
  // Pending bits
  // ----------------------------------------------------------------
  logic pend_wr;
  logic [15:0] pend_new;
  assign pend_wr = csr_valid_in && csr_sel_in == `CSR_SEL_PENDING;
  assign pend_new = csr_new(pending_store, csr_op_in, wr_low);

  // Machine bits are not software writable
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      top_ext_pending_q <= 1'b0;
      top_soft_pending_q <= 1'b0;
    end else begin
      top_ext_pending_q <= top_ext_req_in;
      top_soft_pending_q <= HAS_TOP_SOFT & top_soft_level_in;
    end
  end

  // A fire in the same cycle as a compare write wins
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      top_timer_pending_q <= 1'b0;
    end else if (timer_fire_in) begin
      top_timer_pending_q <= 1'b1;
    end else if (timer_cmp_write_in) begin
      top_timer_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sup_ext_sw_q <= 1'b0;
      sup_timer_pending_q <= 1'b0;
    end else if (pend_wr) begin
      sup_ext_sw_q <= HAS_SUPER & pend_new[`BIT_SUP_EXT];
      sup_timer_pending_q <= HAS_SUPER & pend_new[`BIT_SUP_TIMER];
    end
  end

  // Controller set wins over a software clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sup_soft_pending_q <= 1'b0;
    end else if (HAS_SUPER && sup_soft_set_in) begin
      sup_soft_pending_q <= 1'b1;
    end else if (pend_wr) begin
      sup_soft_pending_q <= HAS_SUPER & pend_new[`BIT_SUP_SOFT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt decision, combinational so it follows every change
  // ----------------------------------------------------------------
  assign irq_ready = pending_view & enable_q & enable_mask &
    ~(irq_deleg_q & SUP_MASK);

  always_comb begin
    irq_cause_out = 4'h0;
    if (irq_ready[`BIT_TOP_EXT]) begin
      irq_cause_out = 4'(`BIT_TOP_EXT);
    end else if (irq_ready[`BIT_TOP_SOFT]) begin
      irq_cause_out = 4'(`BIT_TOP_SOFT);
    end else if (irq_ready[`BIT_TOP_TIMER]) begin
      irq_cause_out = 4'(`BIT_TOP_TIMER);
    end else if (irq_ready[`BIT_SUP_EXT]) begin
      irq_cause_out = 4'(`BIT_SUP_EXT);
    end else if (irq_ready[`BIT_SUP_SOFT]) begin
      irq_cause_out = 4'(`BIT_SUP_SOFT);
    end else if (irq_ready[`BIT_SUP_TIMER]) begin
      irq_cause_out = 4'(`BIT_SUP_TIMER);
    end
  end

  // No registering: a return or CSR write is seen at once
  assign irq_take_out = (|irq_ready) &&
    (!is_top || top_global_irq_on_in);

  // ----------------------------------------------------------------
  // Exception routing; machine-level interrupt preempts
  // ----------------------------------------------------------------
  assign exc_to_sup = HAS_SUPER && !is_top &&
    exc_deleg_q[exc_code_in] && EXC_MASK[exc_code_in];
  assign trap_to_sup_out = exc_valid_in && !irq_take_out &&
    exc_to_sup;
  assign top_trap_write_out = irq_take_out ||
    (exc_valid_in && !exc_to_sup);

  // ----------------------------------------------------------------
  // Supervisor trap state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sup_trap_cause_out <= '0;
      sup_trap_pc_out <= '0;
      sup_trap_value_out <= '0;
      sup_prior_level_out <= 1'b0;
      sup_prior_irq_on_out <= 1'b0;
      sup_global_irq_on_out <= 1'b0;
    end else if (trap_to_sup_out) begin
      sup_trap_cause_out <= {{(XLEN-4){1'b0}}, exc_code_in};
      sup_trap_pc_out <= exc_pc_in;
      sup_trap_value_out <= exc_value_in;
      sup_prior_level_out <= cur_level_in[0];
      sup_prior_irq_on_out <= sup_global_irq_on_in;
      sup_global_irq_on_out <= 1'b0;
    end else begin
      sup_global_irq_on_out <= sup_global_irq_on_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_no_top_deleg: assert property (@(posedge clock_in) disable iff (srst_in)
    !(exc_valid_in && is_top && trap_to_sup_out))
    else $error("machine level trap delegated");
  chk_bit11_zero: assert property (@(posedge clock_in) disable iff (srst_in)
    csr_sel_in == `CSR_SEL_EXC_DELEG |-> !csr_rdata_out[`EXC_ECALL_TOP])
    else $error("exception delegate bit 11 not zero");
  chk_top_irq_undeleg: assert property (@(posedge clock_in)
    disable iff (srst_in)
    csr_sel_in == `CSR_SEL_IRQ_DELEG |-> (csr_rdata_out[15:0] &
      `IRQ_TOP_MASK) == 16'h0000)
    else $error("machine interrupt delegation bit set");
  chk_timer_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    $fell(top_timer_pending_q) |-> $past(timer_cmp_write_in))
    else $error("timer pending cleared without compare write");
  chk_ext_follow: assert property (@(posedge clock_in) disable iff (srst_in)
    top_ext_req_in ##1 !srst_in |-> top_ext_pending_q)
    else $error("external pending did not follow request");
  chk_sup_ext_or: assert property (@(posedge clock_in) disable iff (srst_in)
    HAS_SUPER && sup_ext_req_in && csr_sel_in == `CSR_SEL_PENDING
      |-> csr_rdata_out[`BIT_SUP_EXT])
    else $error("supervisor external read not ORed");
  chk_sup_trap_load: assert property (@(posedge clock_in) disable iff (srst_in)
    trap_to_sup_out |=> sup_trap_pc_out == $past(exc_pc_in) &&
      !sup_global_irq_on_out &&
      sup_prior_irq_on_out == $past(sup_global_irq_on_in))
    else $error("supervisor trap state not loaded");
  chk_irq_prio: assert property (@(posedge clock_in) disable iff (srst_in)
    irq_ready[`BIT_TOP_EXT] |-> irq_cause_out == 4'hB)
    else $error("machine external not highest priority");
  chk_top_mask: assert property (@(posedge clock_in) disable iff (srst_in)
    is_top && !top_global_irq_on_in |-> !irq_take_out)
    else $error("interrupt taken while machine disabled");
  chk_excl: assert property (@(posedge clock_in) disable iff (srst_in)
    !(trap_to_sup_out && top_trap_write_out))
    else $error("delegated trap also writes machine state");

  // ----------------------------------------------------------------
  // Register view and source checks
  // ----------------------------------------------------------------
  chk_deleg_irq_mask: assert property (@(posedge clock_in)
    disable iff (srst_in)
    !(irq_take_out && is_top &&
      (pending_view & enable_q & ~irq_deleg_q) == 16'h0000))
    else $error("delegated interrupt taken at machine level");

  chk_pend_low_zero: assert property (@(posedge clock_in)
    disable iff (srst_in)
    csr_sel_in == `CSR_SEL_PENDING |->
      (csr_rdata_out[15:0] & 16'hF555) == 16'h0000)
    else $error("unused pending bit reads one");

  chk_en_low_zero: assert property (@(posedge clock_in)
    disable iff (srst_in)
    csr_sel_in == `CSR_SEL_ENABLE |->
      (csr_rdata_out[15:0] & 16'hF555) == 16'h0000)
    else $error("unused enable bit reads one");

  chk_high_zero: assert property (@(posedge clock_in)
    disable iff (srst_in)
    csr_rdata_out[XLEN-1:16] == '0)
    else $error("upper read bits not zero");

  chk_sup_keep: assert property (@(posedge clock_in)
    disable iff (srst_in)
    !trap_to_sup_out |=> sup_trap_pc_out == $past(sup_trap_pc_out))
    else $error("supervisor trap pc changed without trap");

  chk_timer_set: assert property (@(posedge clock_in)
    disable iff (srst_in)
    timer_fire_in |=> top_timer_pending_q)
    else $error("timer fire did not set pending");

  chk_sw_clear: assert property (@(posedge clock_in)
    disable iff (srst_in)
    pend_wr && csr_op_in == trap_deleg_pkg::CSR_OP_WRITE &&
      !wr_low[`BIT_SUP_TIMER] |=> !sup_timer_pending_q)
    else $error("writing zero did not clear pending");

  chk_cause_taken: assert property (@(posedge clock_in)
    disable iff (srst_in)
    irq_take_out |-> irq_ready[irq_cause_out])
    else $error("reported cause not ready");

endmodule : trap_delegation_interrupt_ctrl
